/* File: rtl/display_port_pkg.sv */
package display_port_pkg;

  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int GP_PINS = 7;
  localparam int CNT_W = 12;
  localparam int HALF_W = CNT_W + 1;
  localparam int BUS_W = 24;
  localparam int COMP_W = 8;
  localparam int GROUPS = 3;
  localparam int FIFO_DEPTH = 4;

  // ------------------------------------------------------------
  // Divider and PWM defaults
  // ------------------------------------------------------------
  localparam int HALF_DIV_DEFAULT = 1;
  localparam int PWM_W = 8;

  // ------------------------------------------------------------
  // Embedded reference codes of the 8-bit luma/chroma mode
  // ------------------------------------------------------------
  localparam logic [7:0] CODE_LEAD = 8'h00_FF;
  localparam logic [7:0] CODE_ZERO = 8'h00_00;
  localparam logic [7:0] BLANK_LUMA = 8'h00_10;
  localparam logic [7:0] BLANK_CHROMA = 8'h00_80;
  localparam int CODE_LEN = 4;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_RGB = 2'b00,
    MODE_YC8 = 2'b01,
    MODE_ASYNC = 2'b10
  } mode_type;

  // One data word with the flags that steer the asynchronous pins
  typedef struct packed {
    logic [COMP_W-1:0] red;
    logic [COMP_W-1:0] green;
    logic [COMP_W-1:0] blue;
    logic [GP_PINS-1:0] flags;
    logic cs_sel;
  } word_type;

  // Edge points in half interface clocks (line based) or lines
  typedef struct packed {
    logic line_base;
    logic invert;
    logic [HALF_W-1:0] up;
    logic [HALF_W-1:0] down;
  } pin_cfg_type;

  typedef struct packed {
    logic [CNT_W-1:0] screen_width;
    logic [CNT_W-1:0] h_lead;
    logic [CNT_W-1:0] h_len;
    logic [CNT_W-1:0] screen_height;
    logic [CNT_W-1:0] v_lead;
    logic [CNT_W-1:0] v_len;
  } frame_cfg_type;

  typedef struct packed {
    logic [4:0] offset;
    logic [3:0] width;
  } group_type;

endpackage

/* File: rtl/word_fifo.sv */
`timescale 1ns/10ps
module word_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int AW = $clog2(DEPTH);

  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
    $error("word_fifo needs a power-of-two depth of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  // Write side
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
    end else if (in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Read side
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_ptr <= '0;
    end else if (out_ready && !empty) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule

/* File: rtl/display_port_signal_generator.sv */
`timescale 1ns/10ps
// Overview of operation
// - Separate synchronous and asynchronous output pin groups
// - Synchronous controls repeat with fixed period, waveform
// - Dedicated clock output is the pixel base
// - Seven synchronous pins carry any periodic signal
// - Chained counters; up/down edges, half-clock resolution
// - Asynchronous pins follow per-word flags
// - Two chip selects address two panels
// - Seven asynchronous pins carry strobes or selects
// - Each new word restarts asynchronous edge generators
// - 8-bit luma/chroma embeds codes, no ancillary data
// - Pin and bit assignment is configurable
// - Second chip select doubles as PWM output
// - Dedicated pin carries data-enable strobe
// - One instance per port; reduced pins allowed
// - At most three contiguous non-overlapping bit groups
// - Vertical sync spans a whole horizontal pulse
module display_port_signal_generator
  import display_port_pkg::*;
#(
  parameter int HALF_DIV = HALF_DIV_DEFAULT,
  parameter int SYNC_PINS_USED = GP_PINS,
  parameter int ASYNC_PINS_USED = GP_PINS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire mode_type mode,
  input wire frame_cfg_type frame,
  input wire pin_cfg_type [GP_PINS-1:0] sync_cfg,
  input wire pin_cfg_type [GP_PINS-1:0] async_cfg,
  input wire logic [HALF_W-1:0] async_len,
  input wire group_type [GROUPS-1:0] groups,
  input wire logic select_invert,
  input wire logic valid_invert,
  input wire logic pwm_enable,
  input wire logic [PWM_W-1:0] pwm_duty,
  input wire logic tear_sync_en,
  input wire logic vsync_in,
  input wire word_type in_word,
  input wire logic in_valid,
  output logic in_ready,
  output logic pixel_rate_clock,
  output logic [BUS_W-1:0] pixel_bus,
  output logic [GP_PINS-1:0] sync_pins,
  output logic pixel_valid_strobe,
  output logic panel_select_zero,
  output logic panel_select_one,
  output logic [GP_PINS-1:0] async_pins,
  output logic underrun,
  output logic group_overlap
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (HALF_DIV < 1 || SYNC_PINS_USED > GP_PINS || ASYNC_PINS_USED > GP_PINS
      || SYNC_PINS_USED < 0 || ASYNC_PINS_USED < 0) begin : g_bad
    $error("display port parameters out of range");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01
  } async_state_type;

  localparam int DIV_W = $clog2(HALF_DIV + 1);

  logic [DIV_W-1:0] div_cnt;
  logic half_tick;
  logic phase;
  logic di_tick;
  logic period_start;
  logic [HALF_W-1:0] hpos;
  logic [CNT_W-1:0] vpos;
  logic [CNT_W-1:0] hdi;
  logic line_end;
  logic h_active;
  logic v_active;
  logic active;
  logic yc_phase;
  logic vsync_meta;
  logic vsync_sync;
  async_state_type astate;
  logic [HALF_W-1:0] acnt;
  word_type aword;
  word_type fifo_word;
  logic fifo_valid;
  logic fifo_pop;
  logic sync_pop;
  logic async_start;
  logic [PWM_W-1:0] pwm_cnt;
  logic [BUS_W-1:0] mapped_live;
  logic [BUS_W-1:0] mapped_async;
  logic [7:0] yc_byte;

  // ------------------------------------------------------------
  // Data buffer
  // ------------------------------------------------------------
  word_fifo #(
    .WIDTH($bits(word_type)),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_data(in_word),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .out_data(fifo_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // ------------------------------------------------------------
  // Interface clock divider
  // ------------------------------------------------------------

  // Half-period enable gives the half-clock edge resolution
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !enable) begin
      div_cnt <= '0;
    end else if (half_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  assign half_tick = enable && (div_cnt == DIV_W'(HALF_DIV - 1));
  assign di_tick = half_tick && phase;

  // Phase: low in first half of an interface clock, high in second
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !enable) begin
      phase <= 1'b0;
    end else if (half_tick) begin
      phase <= !phase;
    end
  end

  // Registered boundary of each interface clock period
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      period_start <= 1'b0;
    end else begin
      period_start <= di_tick;
    end
  end

  // pixel clock base
  // Registered from a low phase, so high for one half of each interface clock period, one system clock after the first half starts
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pixel_rate_clock <= 1'b0;
    end else begin
      pixel_rate_clock <= enable && !phase;
    end
  end

  // ------------------------------------------------------------
  // Line and frame counters
  // ------------------------------------------------------------
  assign line_end = (hpos == HALF_W'({frame.screen_width, 1'b0} - 1'b1));

  // chained start counters
  // Line counter wraps first; frame counter steps on its wrap
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !enable) begin
      hpos <= '0;
    end else if (half_tick) begin
      hpos <= line_end ? '0 : hpos + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !enable) begin
      vpos <= '0;
    end else if (half_tick && line_end) begin
      vpos <= (vpos == frame.screen_height - 1'b1) ? '0 : vpos + 1'b1;
    end
  end

  assign hdi = hpos[HALF_W-1:1];
  assign h_active = ({1'b0, hdi} >= {1'b0, frame.h_lead})
    && ({1'b0, hdi} < ({1'b0, frame.h_lead} + {1'b0, frame.h_len}));
  assign v_active = ({1'b0, vpos} >= {1'b0, frame.v_lead})
    && ({1'b0, vpos} < ({1'b0, frame.v_lead} + {1'b0, frame.v_len}));
  assign active = h_active && v_active;

  // ------------------------------------------------------------
  // Synchronous pins
  // ------------------------------------------------------------

  for (genvar i = 0; i < GP_PINS; i++) begin : g_sync
    logic level;
    // frame pins span lines
    // Frame-based pins move only at line starts, so each covers whole lines
    assign level = sync_cfg[i].line_base
      ? (hpos >= sync_cfg[i].up && hpos < sync_cfg[i].down)
      : ({1'b0, vpos} >= sync_cfg[i].up && {1'b0, vpos} < sync_cfg[i].down);
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        sync_pins[i] <= 1'b0;
      end else begin
        sync_pins[i] <= (i < SYNC_PINS_USED) && enable && mode != MODE_ASYNC
          && (level ^ sync_cfg[i].invert);
      end
    end
  end

  // ------------------------------------------------------------
  // Bit group mapping
  // ------------------------------------------------------------

  function automatic logic [BUS_W-1:0] map_word(input word_type w,
                                                input group_type [GROUPS-1:0] g);
    logic [BUS_W-1:0] bus;
    logic [COMP_W-1:0] comp [GROUPS];
    logic [COMP_W-1:0] bits;
    bus = '0;
    comp[0] = w.blue;
    comp[1] = w.green;
    comp[2] = w.red;
    for (int k = 0; k < GROUPS; k++) begin
      bits = (g[k].width >= 4'(COMP_W)) ? comp[k] : comp[k] >> (4'(COMP_W) - g[k].width);
      bus = bus | BUS_W'({16'h0000, bits} << g[k].offset);
    end
    return bus;
  endfunction

  // Footprint of each group, to flag overlapping layouts
  function automatic logic [BUS_W-1:0] group_mask(input group_type g);
    logic [BUS_W-1:0] ones;
    ones = BUS_W'((32'h0000_0001 << g.width) - 32'h0000_0001);
    return BUS_W'({8'h00, ones} << g.offset);
  endfunction

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      group_overlap <= 1'b0;
    end else begin
      group_overlap <= |(group_mask(groups[0]) & group_mask(groups[1]))
        || |(group_mask(groups[0]) & group_mask(groups[2]))
        || |(group_mask(groups[1]) & group_mask(groups[2]));
    end
  end

  // default RGB layout
  // With offsets 0, 8, 16 and width 8 this gives blue, green, red upward
  assign mapped_live = map_word(fifo_word, groups);
  assign mapped_async = map_word(aword, groups);

  // ------------------------------------------------------------
  // Luma/chroma byte stream
  // ------------------------------------------------------------

  // embedded reference codes
  // Codes every line; blanking carries only fill levels, no ancillary data
  always_comb begin
    logic [CNT_W:0] eav_at;
    logic [CNT_W:0] sav_at;
    logic [CNT_W:0] pos;
    logic eav;
    logic sav;
    logic [1:0] k;
    logic vb;
    eav_at = {1'b0, frame.h_lead} + {1'b0, frame.h_len};
    sav_at = {1'b0, frame.h_lead} - (CNT_W + 1)'(CODE_LEN);
    pos = {1'b0, hdi};
    eav = pos >= eav_at && pos < eav_at + (CNT_W + 1)'(CODE_LEN);
    sav = pos >= sav_at && pos < {1'b0, frame.h_lead};
    k = eav ? 2'(pos - eav_at) : 2'(pos - sav_at);
    vb = !v_active;
    if (eav || sav) begin
      unique case (k)
        2'd0: yc_byte = CODE_LEAD;
        2'd1: yc_byte = CODE_ZERO;
        2'd2: yc_byte = CODE_ZERO;
        default: yc_byte = {1'b1, 1'b0, vb, eav, vb ^ eav, eav, vb, vb ^ eav};
      endcase
    end else if (active) begin
      yc_byte = yc_phase ? fifo_word.green : fifo_word.blue;
    end else begin
      yc_byte = hdi[0] ? BLANK_LUMA : BLANK_CHROMA;
    end
  end

  // Chroma then luma within each pixel
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !active) begin
      yc_phase <= 1'b0;
    end else if (period_start) begin
      yc_phase <= !yc_phase;
    end
  end

  // ------------------------------------------------------------
  // Buffer drain
  // ------------------------------------------------------------
  assign sync_pop = period_start && active && fifo_valid
    && (mode == MODE_RGB || (mode == MODE_YC8 && yc_phase));
  assign fifo_pop = sync_pop || async_start;

  // Missing word during active display is reported, bus shows zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      underrun <= 1'b0;
    end else if (period_start && active && mode != MODE_ASYNC) begin
      underrun <= !fifo_valid;
    end
  end

  // ------------------------------------------------------------
  // Data bus and enable strobe
  // ------------------------------------------------------------

  always_ff @(posedge sys_clk) begin
    if (!rst_n || !enable) begin
      pixel_bus <= '0;
    end else if (mode == MODE_ASYNC) begin
      pixel_bus <= (astate == ST_RUN) ? mapped_async : '0;
    end else if (period_start) begin
      if (mode == MODE_YC8) begin
        pixel_bus <= {16'h0000, fifo_valid || !active ? yc_byte : 8'h00};
      end else begin
        pixel_bus <= (active && fifo_valid) ? mapped_live : '0;
      end
    end
  end

  // data-enable strobe
  // Marks valid pixels; inactive shows blanking
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pixel_valid_strobe <= 1'b0;
    end else if (!enable) begin
      pixel_valid_strobe <= valid_invert;
    end else if (mode == MODE_ASYNC) begin
      pixel_valid_strobe <= (astate == ST_RUN) ^ valid_invert;
    end else if (period_start) begin
      pixel_valid_strobe <= active ^ valid_invert;
    end
  end

  // ------------------------------------------------------------
  // Asynchronous engine
  // ------------------------------------------------------------

  // Two flip-flops before the returned sync is used
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      vsync_meta <= 1'b0;
      vsync_sync <= 1'b0;
    end else begin
      vsync_meta <= vsync_in;
      vsync_sync <= vsync_meta;
    end
  end

  // tearing guard
  // Level gate only; the panel holds sync long enough for a burst
  assign async_start = mode == MODE_ASYNC && enable && astate == ST_IDLE
    && fifo_valid && (!tear_sync_en || vsync_sync);

  // fresh start point
  // Each word restarts the edge counter in half interface clocks
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      astate <= ST_IDLE;
      acnt <= '0;
      aword <= '0;
    end else begin
      unique case (astate)
        ST_IDLE: begin
          if (async_start) begin
            astate <= ST_RUN;
            acnt <= '0;
            aword <= fifo_word;
          end
        end
        ST_RUN: begin
          if (half_tick) begin
            if (acnt >= async_len - 1'b1) begin
              astate <= ST_IDLE;
            end else begin
              acnt <= acnt + 1'b1;
            end
          end
        end
        default: astate <= ST_IDLE;
      endcase
    end
  end

  for (genvar i = 0; i < GP_PINS; i++) begin : g_async
    logic level;
    assign level = astate == ST_RUN && aword.flags[i]
      && acnt >= async_cfg[i].up && acnt < async_cfg[i].down;
    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        async_pins[i] <= 1'b0;
      end else begin
        async_pins[i] <= (i < ASYNC_PINS_USED) && (level ^ async_cfg[i].invert);
      end
    end
  end

  // ------------------------------------------------------------
  // Chip selects and PWM
  // ------------------------------------------------------------

  // Free-running PWM on the interface clock
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwm_cnt <= '0;
    end else if (di_tick) begin
      pwm_cnt <= pwm_cnt + 1'b1;
    end
  end

  // two panel selects
  // Selected panel is asserted for the whole word cycle, except select one while pwm_enable is set
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      panel_select_zero <= 1'b0;
    end else begin
      panel_select_zero <= (astate == ST_RUN && !aword.cs_sel) ^ select_invert;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      panel_select_one <= 1'b0;
    end else if (pwm_enable) begin
      panel_select_one <= pwm_cnt < pwm_duty;
    end else begin
      panel_select_one <= (astate == ST_RUN && aword.cs_sel) ^ select_invert;
    end
  end

endmodule

/* File: bench/display_port_chk.sv */
`timescale 1ns/10ps
module display_port_chk
  import display_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire mode_type mode,
  input wire frame_cfg_type frame,
  input wire pin_cfg_type [GP_PINS-1:0] sync_cfg,
  input wire pin_cfg_type [GP_PINS-1:0] async_cfg,
  input wire group_type [GROUPS-1:0] groups,
  input wire logic pixel_rate_clock,
  input wire logic [BUS_W-1:0] pixel_bus,
  input wire logic [GP_PINS-1:0] sync_pins,
  input wire logic pixel_valid_strobe,
  input wire logic [GP_PINS-1:0] async_pins,
  input wire logic group_overlap
);
  // ----------
  // Run trackers
  // ----------
  logic [3:0] prev;
  logic [3:0] arm;
  logic v_rise, v_seen;
  logic [15:0] h_cnt, h_per, s_cnt, a_cnt;
  wire [3:0] now = {async_pins[0], pixel_valid_strobe, sync_pins[1], sync_pins[0]};
  wire [3:0] rise = now & ~prev;
  wire [3:0] fall = prev & ~now;
  wire run = rst_n & enable;

  function automatic logic [47:0] span(input group_type g);
    span = ((48'h1 << g.width) - 48'h1) << g.offset;
  endfunction
  wire [47:0] f0 = span(groups[0]);
  wire [47:0] f1 = span(groups[1]);
  wire [47:0] f2 = span(groups[2]);
  wire ovl = |((f0 & f1) | (f0 & f2) | (f1 & f2));

  // Arm only on a full rising edge, so runs cut by reset or disable are not judged
  always_ff @(posedge sys_clk) begin
    prev <= now;
    arm <= {4{run}} & (arm | rise);
  end
  // Run lengths and line period, counted in system cycles
  always_ff @(posedge sys_clk) begin
    h_cnt <= rise[0] ? 16'h0001 : h_cnt + 16'(now[0]);
    h_per <= rise[0] ? 16'h0001 : h_per + 16'h0001;
    s_cnt <= rise[2] ? 16'h0001 : s_cnt + 16'(now[2]);
    a_cnt <= rise[3] ? 16'h0001 : a_cnt + 16'(now[3]);
  end
  // A whole line pulse must start and end inside the frame pulse
  always_ff @(posedge sys_clk) begin
    v_rise <= ~rise[1] & (v_rise | (rise[0] & now[1]));
    v_seen <= ~rise[1] & (v_seen | (fall[0] & v_rise));
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_clock_toggles: assert property ((rst_n && enable)[*4] |->
    pixel_rate_clock != $past(pixel_rate_clock)) else $error("pixel clock stalled");
  a_hsync_width: assert property (fall[0] && arm[0] && enable && sync_cfg[0].line_base
    |-> h_cnt == 16'(sync_cfg[0].down - sync_cfg[0].up)) else $error("line pulse width");
  a_line_period: assert property (rise[0] && arm[0] && enable
    |-> h_per == 16'(2 * frame.screen_width)) else $error("line period");
  a_vsync_span: assert property (fall[1] && arm[1] && enable && !sync_cfg[1].line_base
    |-> v_seen) else $error("frame pulse lacks a line pulse");
  a_strobe_run: assert property (fall[2] && arm[2] && enable && mode == MODE_RGB
    |-> s_cnt == 16'(2 * frame.h_len)) else $error("data enable run length");
  a_async_width: assert property (fall[3] && arm[3] && enable && mode == MODE_ASYNC
    |-> a_cnt == 16'(async_cfg[0].down - async_cfg[0].up)) else $error("strobe width");
  a_group_check: assert property ($past(rst_n) && $stable(groups)
    |-> group_overlap == ovl) else $error("overlap flag");
  a_reset_clear: assert property ($rose(rst_n)
    |-> pixel_bus == '0 && sync_pins == '0 && async_pins == '0) else $error("outputs after reset");
endmodule

bind display_port_signal_generator display_port_chk i_chk (.sys_clk, .rst_n, .enable, .mode,
  .frame, .sync_cfg, .async_cfg, .groups, .pixel_rate_clock, .pixel_bus, .sync_pins,
  .pixel_valid_strobe, .async_pins, .group_overlap);

/* File: bench/smart_panel_model.sv */
`timescale 1ns/10ps
module smart_panel_model
  import display_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hold_sync,
  input wire logic [BUS_W-1:0] pixel_bus,
  input wire logic [GP_PINS-1:0] async_pins,
  input wire logic panel_select_zero,
  input wire logic panel_select_one,
  output logic vsync_in,
  output logic [BUS_W-1:0] seen_word,
  output logic seen_cs,
  output logic [7:0] seen_count
);
  logic [5:0] phase;
  logic prev_wr;
  // Panel frame phase; words may only start in its high half
  always_ff @(posedge sys_clk) begin
    phase <= rst_n ? phase + 6'h01 : 6'h00;
  end
  assign vsync_in = ~hold_sync & phase[5];
  // Latch on the write strobe rising edge, only while a panel is selected
  always_ff @(posedge sys_clk) begin
    prev_wr <= async_pins[0];
    if (!rst_n) begin
      seen_count <= 8'h00;
    end else if (async_pins[0] && !prev_wr && (panel_select_zero || panel_select_one)) begin
      seen_word <= pixel_bus;
      seen_cs <= panel_select_one;
      seen_count <= seen_count + 8'h01;
    end
  end
endmodule

/* File: bench/display_port_signal_generator_test.sv */
`timescale 1ns/10ps
module display_port_signal_generator_test import display_port_pkg::*;;
  logic sys_clk, rst_n, enable, select_invert, valid_invert, pwm_enable, tear_sync_en;
  logic vsync_in, in_valid, in_ready, pixel_rate_clock, pixel_valid_strobe, hold_sync;
  logic panel_select_zero, panel_select_one, underrun, group_overlap, seen_cs;
  mode_type mode;
  frame_cfg_type frame;
  pin_cfg_type [GP_PINS-1:0] sync_cfg, async_cfg;
  logic [HALF_W-1:0] async_len;
  group_type [GROUPS-1:0] groups;
  logic [PWM_W-1:0] pwm_duty;
  word_type in_word;
  logic [BUS_W-1:0] pixel_bus, seen_word;
  logic [GP_PINS-1:0] sync_pins, async_pins;
  logic [7:0] seen_count;
  int errors, comparisons;
  localparam group_type [2:0] GRP_STD = {5'h10, 4'h8, 5'h08, 4'h8, 5'h00, 4'h8};
  localparam group_type [2:0] GRP_BAD = {5'h10, 4'h8, 5'h04, 4'h8, 5'h00, 4'h8};
  localparam group_type [2:0] GRP_SWAP = {5'h00, 4'h8, 5'h08, 4'h8, 5'h10, 4'h8};
  localparam word_type WORD_A = {8'hAA, 8'h55, 8'hC3, 7'h01, 1'b0};
  localparam word_type WORD_B = {8'h12, 8'h34, 8'h56, 7'h01, 1'b1};
  localparam word_type WORD_C = {8'h0F, 8'hF0, 8'h3C, 7'h00, 1'b0};

  display_port_signal_generator i_dut (.sys_clk, .rst_n, .enable, .mode, .frame, .sync_cfg,
    .async_cfg, .async_len, .groups, .select_invert, .valid_invert, .pwm_enable, .pwm_duty,
    .tear_sync_en, .vsync_in, .in_word, .in_valid, .in_ready, .pixel_rate_clock, .pixel_bus,
    .sync_pins, .pixel_valid_strobe, .panel_select_zero, .panel_select_one, .async_pins,
    .underrun, .group_overlap);
  smart_panel_model i_panel (.sys_clk, .rst_n, .hold_sync, .pixel_bus, .async_pins,
    .panel_select_zero, .panel_select_one, .vsync_in, .seen_word, .seen_cs, .seen_count);

  // ----------
  // Shared tasks
  // ----------
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    if (errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  function automatic logic hit(input int sel);
    case (sel)
      0: hit = pixel_valid_strobe === 1'b1;
      1: hit = pixel_bus[7:0] === 8'hFF;
      2: hit = panel_select_one === 1'b1;
      default: hit = seen_count === 8'(sel - 2);
    endcase
  endfunction
  // Bounded wait; a miss falls through to the comparison that follows
  task automatic wait_hi(input int sel, input int lim);
    int n;
    n = 0;
    while (n < lim && !hit(sel)) begin
      @(negedge sys_clk);
      n++;
    end
  endtask
  // Hold valid until a beat is taken; ready is read on the settled half cycle
  task automatic push(input word_type w);
    logic rdy;
    rdy = 1'b0;
    @(posedge sys_clk);
    in_word <= w;
    in_valid <= 1'b1;
    while (rdy !== 1'b1) begin
      @(negedge sys_clk);
      rdy = in_ready;
      @(posedge sys_clk);
    end
    in_valid <= 1'b0;
  endtask
  task automatic restart(input mode_type m, input group_type [2:0] g);
    @(posedge sys_clk);
    enable <= 1'b0;
    mode <= m;
    groups <= g;
  endtask
  task automatic go;
    @(posedge sys_clk);
    enable <= 1'b1;
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_fill_rgb;
    restart(MODE_RGB, GRP_STD);
    repeat (4) push(WORD_A);
    cyc(1);
    chk("in_ready full", 24'h0, 24'(in_ready));
    go();
    wait_hi(0, 400);
    chk("rgb pixel", 24'hAA_55C3, pixel_bus);
    cyc(10);
    chk("underrun", 24'h1, 24'(underrun));
    chk("underrun data", 24'h0, pixel_bus);
    chk("strobe", 24'h1, 24'(pixel_valid_strobe));
    chk("in_ready drained", 24'h1, 24'(in_ready));
    cyc(200);
  endtask
  task automatic t_groups;
    restart(MODE_RGB, GRP_BAD);
    cyc(3);
    chk("overlap set", 24'h1, 24'(group_overlap));
    restart(MODE_RGB, GRP_SWAP);
    push(WORD_A);
    cyc(2);
    chk("overlap clear", 24'h0, 24'(group_overlap));
    go();
    wait_hi(0, 400);
    chk("remapped pixel", 24'hC3_55AA, pixel_bus);
  endtask
  task automatic t_yc8;
    logic [7:0] b [3];
    restart(MODE_YC8, GRP_STD);
    go();
    wait_hi(1, 400);
    for (int i = 0; i < 3; i++) begin
      cyc(2);
      b[i] = pixel_bus[7:0];
    end
    chk("reference code", 24'h00_00B6, {b[0], b[1], b[2]});
  endtask
  task automatic t_async;
    restart(MODE_ASYNC, GRP_STD);
    async_cfg[0] <= {1'b0, 1'b0, 13'h0001, 13'h0003};
    async_len <= 13'h0006;
    tear_sync_en <= 1'b1;
    go();
    push(WORD_A);
    cyc(100);
    chk("gated words", 24'h0, 24'(seen_count));
    @(posedge sys_clk);
    hold_sync <= 1'b0;
    wait_hi(3, 300);
    chk("first word", 24'hAA_55C3, seen_word);
    chk("first select", 24'h0, 24'(seen_cs));
    push(WORD_B);
    wait_hi(4, 300);
    chk("second word", 24'h12_3456, seen_word);
    chk("second select", 24'h1, 24'(seen_cs));
    push(WORD_C);
    cyc(100);
    chk("flagless word", 24'h2, 24'(seen_count));
  endtask
  task automatic t_pwm;
    @(posedge sys_clk);
    pwm_duty <= 8'hFF;
    pwm_enable <= 1'b1;
    wait_hi(2, 40);
    chk("pwm high", 24'h1, 24'(panel_select_one));
    @(posedge sys_clk);
    pwm_duty <= 8'h00;
    {select_invert, valid_invert} <= 2'b11;
    cyc(600);
    chk("pwm low", 24'h0, 24'(panel_select_one));
    chk("inverted idle", 24'h3, 24'({panel_select_zero, pixel_valid_strobe}));
  endtask

  // Clock, then a watchdog well past the expected run length
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #1000000;
    errors++;
    give_verdict();
  end
  initial begin
    errors = 0;
    comparisons = 0;
    {rst_n, enable, select_invert, valid_invert, pwm_enable, tear_sync_en, in_valid} = '0;
    hold_sync = 1'b1;
    mode = MODE_RGB;
    frame = {12'h014, 12'h004, 12'h008, 12'h006, 12'h001, 12'h003};
    sync_cfg = '0;
    sync_cfg[0] = {1'b1, 1'b0, 13'h0002, 13'h0006};
    sync_cfg[1] = {1'b0, 1'b0, 13'h0001, 13'h0003};
    async_cfg = '0;
    async_len = 13'h0001;
    groups = GRP_STD;
    pwm_duty = 8'h00;
    in_word = '0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_fill_rgb();
    t_groups();
    t_yc8();
    t_async();
    t_pwm();
    give_verdict();
  end
endmodule
